// >>> stu_core_model.sv
// Processor core model: cycles, first instruction, refresh
`timescale 1ns/1ps
module stu_core_model (
   // Clock and reset
   input wire clk_sys,
   input wire srst,
   // Requests
   input wire core_reset,
   input wire ref_req,
   // Core events
   output reg proc_cycle,
   output reg first_instr,
   output reg refresh_exec
);
   reg boot_reg;
   always @(posedge clk_sys) begin
      if (srst || core_reset) begin
         proc_cycle <= 1'b0;
         first_instr <= 1'b0;
         refresh_exec <= 1'b0;
         boot_reg <= 1'b1;
      end else begin
         proc_cycle <= ~proc_cycle;
         first_instr <= boot_reg;
         boot_reg <= 1'b0;
         refresh_exec <= ref_req;
      end
   end
endmodule // stu_core_model

// >>> stu_defines.vh
// Constants shared by the supervision timeout unit
`ifndef STU_DEFINES_VH
`define STU_DEFINES_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define STU_BANK_CFG 4'hf
`define STU_ADDR_MODE_CFG 8'h0f
`define STU_READ_FILL 8'hff

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define STU_TAP_LSB 0
`define STU_TAP_MSB 1
`define STU_HALT_RUN_BIT 2
`define STU_STOP_RUN_BIT 3
`define STU_MODE_RESET 8'h01

// ----------------------------------------
// Timing
// ----------------------------------------
`define STU_WINDOW_PROC_CYCLES 60
`define STU_WINDOW_CRYSTAL_CLOCK_CLOCKS 120
`define STU_CNT_WIDTH 22
`define STU_TAP0_BIT 14
`define STU_TAP1_BIT 16
`define STU_TAP2_BIT 18
`define STU_TAP3_BIT 21

// ----------------------------------------
// Flag register bit positions
// ----------------------------------------
`define STU_FLAG_V 2
`define STU_FLAG_S 3
`define STU_FLAG_Z 4

`endif

// >>> stu_supervision_timer.v
// Supervision timeout unit: watchdog counter, mode register writable only in a startup window, core reset
// Behaviour
// - Retriggerable one-shot, terminal count resets core
// - Inactive until first refresh instruction
// - Later refresh instructions restart the count
// - Refresh updates zero, sign, overflow flags
// - Counter runs on internal RC oscillator
// - Mode bits 1:0 select timeout tap
// - Mode bit 2 enables counting in Halt
// - Mode bit 3 enables counting in Stop
// - Mode bits 7:4 reserved, no effect
// - Writes accepted only first 60 processor cycles
// - Later writes ignored until next reset or stop recovery event
// - Mode register is write-only
// - Mode register at 0Fh of bank F
`timescale 1ns/1ps
`include "stu_defines.vh"
module stu_supervision_timer (
   // Clock and reset
   input wire clk_sys,
   input wire srst,
   // RC oscillator, asynchronous to clk_sys
   input wire rc_osc,
   // Core register-file access
   input wire [3:0] reg_bank,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // Core instruction and state
   input wire proc_cycle,
   input wire first_instr,
   input wire refresh_exec,
   input wire halt_mode,
   input wire stop_mode,
   input wire stop_recovery_event,
   input wire [7:0] flags_in,
   // Outputs to core
   output reg [7:0] flags_out,
   output reg flags_we,
   output reg core_reset,
   output wire timer_enabled,
   output wire mode_window_open
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   reg [7:0] mode_reg;
   reg [7:0] mode_next;
   reg win_open_reg;
   reg win_armed_reg;
   reg [5:0] win_cnt_reg;
   reg enabled_reg;
   reg [`STU_CNT_WIDTH-1:0] cnt_reg;
   reg [`STU_CNT_WIDTH-1:0] cnt_next;
   reg rc_prev_reg;
   reg tap_bit;
   wire rc_sync;
   wire rc_rise;
   wire mode_hit;
   wire run_ok;
   wire terminal;

   // ----------------------------------------
   // Oscillator crossing
   // ----------------------------------------
   stu_sync u_rc_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .din(rc_osc),
      .dout(rc_sync)
   );

   always @(posedge clk_sys) begin
      if (srst) begin
         rc_prev_reg <= 1'b0;
      end else begin
         rc_prev_reg <= rc_sync;
      end
   end

   // The watchdog count advances only on RC edges, never on clk_sys directly
   assign rc_rise = rc_sync & ~rc_prev_reg;

   // ----------------------------------------
   // Mode register and write window
   // ----------------------------------------
   assign mode_hit = (reg_bank == `STU_BANK_CFG) && (reg_addr == `STU_ADDR_MODE_CFG);

   always @* begin
      mode_next = mode_reg;
      if (reg_wr && mode_hit && win_open_reg) begin
         mode_next = reg_wdata;
      end
   end

   // Window opens on the first instruction after a qualifying event
   always @(posedge clk_sys) begin
      if (srst) begin
         mode_reg <= `STU_MODE_RESET;
         win_armed_reg <= 1'b1;
         win_open_reg <= 1'b0;
         win_cnt_reg <= 6'h00;
      end else begin
         mode_reg <= mode_next;
         if (stop_recovery_event || core_reset) begin
            win_armed_reg <= 1'b1;
            win_open_reg <= 1'b0;
            win_cnt_reg <= 6'h00;
         end else if (win_armed_reg && first_instr) begin
            win_armed_reg <= 1'b0;
            win_open_reg <= 1'b1;
            win_cnt_reg <= 6'h00;
         end else if (win_open_reg && proc_cycle) begin
            if ({26'h0000000, win_cnt_reg} == (`STU_WINDOW_PROC_CYCLES - 1)) begin
               win_open_reg <= 1'b0;
            end
            win_cnt_reg <= win_cnt_reg + 6'h01;
         end
      end
   end

   assign mode_window_open = win_open_reg;

   // Configuration never leaks on a read of the mode location
   always @(posedge clk_sys) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd && mode_hit) begin
         reg_rdata <= `STU_READ_FILL;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // Tap select and run gating
   // ----------------------------------------
   // Bits 7:4 are stored but never read
   always @* begin
      case (mode_reg[`STU_TAP_MSB:`STU_TAP_LSB])
         2'h0: tap_bit = cnt_reg[`STU_TAP0_BIT];
         2'h1: tap_bit = cnt_reg[`STU_TAP1_BIT];
         2'h2: tap_bit = cnt_reg[`STU_TAP2_BIT];
         2'h3: tap_bit = cnt_reg[`STU_TAP3_BIT];
         default: tap_bit = 1'b0;
      endcase
   end

   assign terminal = tap_bit;
   assign run_ok = (!halt_mode || mode_reg[`STU_HALT_RUN_BIT]) &&
                   (!stop_mode || mode_reg[`STU_STOP_RUN_BIT]);

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always @* begin
      cnt_next = cnt_reg;
      if (refresh_exec) begin
         cnt_next = {`STU_CNT_WIDTH{1'b0}};
      end else if (enabled_reg && run_ok && rc_rise && !terminal) begin
         cnt_next = cnt_reg + {{(`STU_CNT_WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         enabled_reg <= 1'b0;
         cnt_reg <= {`STU_CNT_WIDTH{1'b0}};
         core_reset <= 1'b0;
      end else if (core_reset) begin
         // One-cycle pulse; the reset then clears the unit
         enabled_reg <= 1'b0;
         cnt_reg <= {`STU_CNT_WIDTH{1'b0}};
         core_reset <= 1'b0;
      end else begin
         if (refresh_exec) begin
            enabled_reg <= 1'b1;
         end
         cnt_reg <= cnt_next;
         core_reset <= enabled_reg && terminal && !refresh_exec;
      end
   end

   assign timer_enabled = enabled_reg;

   // ----------------------------------------
   // Flag update on refresh
   // ----------------------------------------
   // Z set, S and V cleared: refresh behaves as loading a zero result
   always @(posedge clk_sys) begin
      if (srst) begin
         flags_out <= 8'h00;
         flags_we <= 1'b0;
      end else begin
         flags_we <= refresh_exec;
         if (refresh_exec) begin
            flags_out <= flags_in;
            flags_out[`STU_FLAG_Z] <= 1'b1;
            flags_out[`STU_FLAG_S] <= 1'b0;
            flags_out[`STU_FLAG_V] <= 1'b0;
         end
      end
   end
endmodule // stu_supervision_timer

// >>> stu_supervision_timer_assertions.sv
// Port-level checks for the supervision timeout unit
`timescale 1ns/1ps
module stu_chk (
   // Clock and reset
   input wire clk_sys,
   input wire srst,
   // Register access
   input wire [3:0] reg_bank,
   input wire [7:0] reg_addr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // Core side
   input wire first_instr,
   input wire refresh_exec,
   input wire [7:0] flags_out,
   input wire flags_we,
   input wire core_reset,
   input wire timer_enabled,
   input wire mode_window_open
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_ref; refresh_exec ##1 flags_we; endsequence
   sequence s_cfg_rd; reg_rd && reg_bank == 4'hf && reg_addr == 8'h0f; endsequence
   property p_flag; s_ref |-> flags_out[4:2] == 3'b100 && timer_enabled; endproperty
   a_flag: assert property (p_flag) else $error("bad flags after refresh");
   property p_we; refresh_exec |=> flags_we; endproperty
   a_we: assert property (p_we) else $error("no flag write");
   property p_rd; s_cfg_rd |=> reg_rdata == 8'hff; endproperty
   a_rd: assert property (p_rd) else $error("mode readable");
   property p_rdo; reg_rd && reg_addr != 8'h0f |=> reg_rdata == 8'h00; endproperty
   a_rdo: assert property (p_rdo) else $error("wrong location decoded");
   property p_pulse; core_reset |=> !core_reset; endproperty
   a_pulse: assert property (p_pulse) else $error("reset not a pulse");
   property p_win; first_instr |=> mode_window_open; endproperty
   a_win: assert property (p_win) else $error("window not opened");
   property p_open; $rose(mode_window_open) |-> $past(first_instr); endproperty
   a_open: assert property (p_open) else $error("window opened late");
   property p_hold; refresh_exec |=> !core_reset [*8]; endproperty
   a_hold: assert property (p_hold) else $error("reset after refresh");
endmodule // stu_chk

bind stu_supervision_timer stu_chk u_chk (.*);

// >>> stu_supervision_timer_tb.sv
// Testbench for the supervision timeout unit
`timescale 1ns/1ps
module stu_supervision_timer_tb;
   reg clk_sys = 0, srst = 1, rc_osc = 0, reg_wr = 0, reg_rd = 0, ref_req = 0;
   reg halt_mode = 0, stop_mode = 0, stop_recovery_event = 0;
   reg [3:0] reg_bank = 4'hf;
   reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, flags_in = 8'h00, d;
   wire [7:0] reg_rdata, flags_out;
   wire proc_cycle, first_instr, refresh_exec, flags_we, core_reset, timer_enabled, mode_window_open;
   integer error_cnt = 0, cmp_count = 0, cyc = 0, n;
   stu_supervision_timer dut (.*);
   stu_core_model core (.*);
   always #20 clk_sys = ~clk_sys;
   // Unrelated to the system clock on purpose
   always #53 rc_osc = ~rc_osc;
   task chk(input [31:0] g, input [31:0] e); begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   end endtask
   task cyc_n(input integer k); repeat (k) @(negedge clk_sys); endtask
   task wr(input [7:0] a, input [7:0] v); begin
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1;
      cyc_n(1);
      reg_wr = 0;
   end endtask
   task rd(input [7:0] a); begin
      reg_addr = a;
      reg_rd = 1;
      cyc_n(1);
      reg_rd = 0;
      d = reg_rdata;
   end endtask
   task t_window; begin
      n = 0;
      while (mode_window_open !== 1'b1 && n < 50) begin
         cyc_n(1);
         n = n + 1;
      end
      chk(mode_window_open, 1);
      // Tap 0, no counting in Halt or Stop, reserved bits set
      reg_bank = 4'he;
      rd(8'h0f);
      reg_bank = 4'hf;
      chk(d, 8'h00);
      wr(8'h0f, 8'hf0);
      rd(8'h0f);
      chk(d, 8'hff);
      rd(8'h0e);
      chk(d, 8'h00);
      cyc_n(130);
      chk(mode_window_open, 0);
      wr(8'h0f, 8'h03);
      $display("window test done");
   end endtask
   task t_refresh; begin
      chk(timer_enabled, 0);
      flags_in = 8'he3;
      ref_req = 1;
      cyc_n(1);
      ref_req = 0;
      cyc_n(1);
      chk(flags_we, 1);
      chk(flags_out & 8'h1c, 8'h10);
      chk(flags_out, 8'hf3);
      chk(timer_enabled, 1);
      $display("refresh test done");
   end endtask
   // Refresh at 10000, then 16384 RC edges of 106 ns, 10000 held in Halt, 1000 in Stop
   task t_timeout; begin
      n = 0;
      while (core_reset !== 1'b1 && n < 70000) begin
         ref_req = (n == 10000);
         halt_mode = (n >= 20000 && n < 30000);
         stop_mode = (n >= 35000 && n < 36000);
         cyc_n(1);
         n = n + 1;
      end
      ref_req = 0;
      chk(n > 64300 && n < 64500, 1);
      cyc_n(4);
      chk(mode_window_open, 1);
      stop_recovery_event = 1;
      cyc_n(1);
      stop_recovery_event = 0;
      cyc_n(1);
      chk(mode_window_open, 0);
      $display("timeout test done");
   end endtask
   task report_and_stop; begin
      $display("checks=%0d errors=%0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   end endtask
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 80000) begin
         error_cnt = error_cnt + 1;
         report_and_stop;
      end
   end
   initial begin
      cyc_n(6);
      srst = 0;
      t_window;
      t_refresh;
      t_timeout;
      report_and_stop;
   end
endmodule // stu_supervision_timer_tb

// >>> stu_sync.v
// Two-stage synchroniser for one level
`timescale 1ns/1ps
module stu_sync (
   // Clock and reset
   input wire clk_sys,
   input wire srst,
   // Level in and out
   input wire din,
   output reg dout
);
   reg meta_reg;

   always @(posedge clk_sys) begin
      if (srst) begin
         meta_reg <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule // stu_sync
